// [design/dcwd_regs.vh]
`ifndef DCWD_REGS_VH
`define DCWD_REGS_VH

// ****************************************************************
// Register map (word addresses on the Avalon-MM port)
// ****************************************************************
`define DCWD_ADDR_W 4
`define DCWD_ADDR_CFG0 4'h0
`define DCWD_ADDR_CFG2 4'h1
`define DCWD_ADDR_STAT 4'h2
`define DCWD_ADDR_RTCFG 4'h3
`define DCWD_ADDR_WPLIM 4'h4

// ****************************************************************
// Field positions in configuration word zero
// ****************************************************************
`define DCWD_PWP_HI 19
`define DCWD_PWP_LO 10
`define DCWD_BOOTWP_BIT 24
`define DCWD_ICE_HI 4
`define DCWD_ICE_LO 3
`define DCWD_JTAG_BIT 2
`define DCWD_DBG_HI 1
`define DCWD_DBG_LO 0

// ****************************************************************
// Field positions in configuration word two
// ****************************************************************
`define DCWD_PLLDIV_HI 2
`define DCWD_PLLDIV_LO 0

// ****************************************************************
// Encodings and constants
// ****************************************************************
`define DCWD_PWP_ALL 10'h000
`define DCWD_PWP_NONE 10'h3ff
`define DCWD_PAGE_SHIFT 10
`define DCWD_ICE_PAIR1 2'h3
`define DCWD_ICE_PAIR2 2'h2
`define DCWD_ICE_PAIR3 2'h1
`define DCWD_DBG_FORCED 2'h3
`define DCWD_PLL_DIV1 3'h0
`define DCWD_PLL_DIV2 3'h1
`define DCWD_PLL_DIV3 3'h2
`define DCWD_PLL_DIV4 3'h3
`define DCWD_PLL_DIV5 3'h4
`define DCWD_PLL_DIV6 3'h5
`define DCWD_PLL_DIV10 3'h6
`define DCWD_PLL_DIV12 3'h7
`define DCWD_LIMIT_W 21
`define DCWD_LIMIT_FULL 21'h1fffff

`endif

// [design/dcwd_decode.v]
// Summary of operation
// - Bits 19-10 of word zero are complement of protected flash page count.
// - Field 0111111111 protects memory below 0x80000; smaller values move boundary up.
// - Field 1011111111 protects memory below 0x40000.
// - All-zero field protects all possible program memory.
// - Page protection applies only when boot-protect bit 24 is cleared.
// - Bits 4-3 pick debugger pair: 11 one, 10 two, 01 three; 00 reserved.
// - Bit 2 enables boundary scan and initialises the runtime JTAG enable bit.
// - Bits 1-0: 1x disables debugger, 0x enables; forced to 11 under code protect.
// - Word two bits 2-0 select PLL input divide 1,2,3,4,5,6,10,12.
`timescale 1ns/1ps
`include "dcwd_regs.vh"

module dcwd_decode (
  input wire clk,
  input wire rst,
  input wire [31:0] cfg_word_zero,
  input wire [31:0] cfg_word_two,
  input wire code_protect,
  input wire [`DCWD_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg [9:0] flash_write_protect_count,
  output reg flash_protect_active,
  output reg [`DCWD_LIMIT_W-1:0] flash_protect_limit,
  output reg [1:0] debug_channel_select,
  output reg debug_pair_one,
  output reg debug_pair_two,
  output reg debug_pair_three,
  output reg debug_enable,
  output reg boundary_scan_port_enable,
  output reg runtime_jtag_enable,
  output reg [2:0] pll_input_divide_select,
  output reg [3:0] pll_input_divide_ratio
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [3:0] pll_ratio;
    input [2:0] sel;
    begin
      case (sel)
        `DCWD_PLL_DIV1: pll_ratio = 4'h1;
        `DCWD_PLL_DIV2: pll_ratio = 4'h2;
        `DCWD_PLL_DIV3: pll_ratio = 4'h3;
        `DCWD_PLL_DIV4: pll_ratio = 4'h4;
        `DCWD_PLL_DIV5: pll_ratio = 4'h5;
        `DCWD_PLL_DIV6: pll_ratio = 4'h6;
        `DCWD_PLL_DIV10: pll_ratio = 4'ha;
        `DCWD_PLL_DIV12: pll_ratio = 4'hc;
        default: pll_ratio = 4'h1;
      endcase
    end
  endfunction

  // Protected pages = ~field; each page is 1 KB, so limit = ~field << 10, except an all-zero field gives the full 0x1fffff.
  function [`DCWD_LIMIT_W-1:0] wp_limit;
    input [9:0] pwp;
    begin
      if (pwp == `DCWD_PWP_ALL)
        wp_limit = `DCWD_LIMIT_FULL;
      else
        wp_limit = {1'b0, ~pwp, 10'h000};
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers (straps may come from outside the clock domain)
  // ****************************************************************
  reg [31:0] w0_s1_q;
  reg [31:0] w0_s2_q;
  reg [31:0] w2_s1_q;
  reg [31:0] w2_s2_q;
  reg cp_s1_q;
  reg cp_s2_q;

  always @(posedge clk)
  begin
    w0_s1_q <= cfg_word_zero;
    w0_s2_q <= w0_s1_q;
    w2_s1_q <= cfg_word_two;
    w2_s2_q <= w2_s1_q;
    cp_s1_q <= code_protect;
    cp_s2_q <= cp_s1_q;
  end

  // ****************************************************************
  // Capture during reset, hold afterwards
  // ****************************************************************
  // Words are loaded on every edge while rst is high, so a long enough
  // reset (3 edges) gives synchronised values; after release nothing changes.
  reg [31:0] w0_q;
  reg [31:0] w2_q;
  reg cp_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      w0_q <= w0_s2_q;
      w2_q <= w2_s2_q;
      cp_q <= cp_s2_q;
    end
  end

  wire [9:0] pwp_w = w0_q[`DCWD_PWP_HI:`DCWD_PWP_LO];
  wire boot_prot_w = ~w0_q[`DCWD_BOOTWP_BIT];
  wire [1:0] ice_w = w0_q[`DCWD_ICE_HI:`DCWD_ICE_LO];
  wire [1:0] dbg_w = cp_q ? `DCWD_DBG_FORCED : w0_q[`DCWD_DBG_HI:`DCWD_DBG_LO];
  wire [2:0] pll_w = w2_q[`DCWD_PLLDIV_HI:`DCWD_PLLDIV_LO];
  wire wp_on_w = boot_prot_w && (pwp_w != `DCWD_PWP_NONE);

  // ****************************************************************
  // Decoded control outputs
  // ****************************************************************
  always @(posedge clk)
  begin
    if (rst)
    begin
      flash_write_protect_count <= 10'h000;
      flash_protect_active <= 1'b0;
      flash_protect_limit <= {`DCWD_LIMIT_W{1'b0}};
      debug_channel_select <= 2'h0;
      debug_pair_one <= 1'b0;
      debug_pair_two <= 1'b0;
      debug_pair_three <= 1'b0;
      debug_enable <= 1'b0;
      boundary_scan_port_enable <= 1'b0;
      pll_input_divide_select <= 3'h0;
      pll_input_divide_ratio <= 4'h1;
    end
    else
    begin
      flash_write_protect_count <= pwp_w;
      flash_protect_active <= wp_on_w;
      flash_protect_limit <= wp_on_w ? wp_limit(pwp_w) : {`DCWD_LIMIT_W{1'b0}};
      debug_channel_select <= ice_w;
      debug_pair_one <= (ice_w == `DCWD_ICE_PAIR1);
      debug_pair_two <= (ice_w == `DCWD_ICE_PAIR2);
      debug_pair_three <= (ice_w == `DCWD_ICE_PAIR3);
      debug_enable <= ~dbg_w[1];
      boundary_scan_port_enable <= w0_q[`DCWD_JTAG_BIT];
      pll_input_divide_select <= pll_w;
      pll_input_divide_ratio <= pll_ratio(pll_w);
    end
  end

  // ****************************************************************
  // Runtime configuration control: JTAG enable bit
  // ****************************************************************
  // Software may turn the port off or back on; reset reloads the strap.
  wire wr_rtcfg_w = avs_write && !avs_waitrequest &&
    (avs_address == `DCWD_ADDR_RTCFG) && avs_byteenable[0];

  always @(posedge clk)
  begin
    if (rst)
      runtime_jtag_enable <= w0_q[`DCWD_JTAG_BIT];
    else if (wr_rtcfg_w)
      runtime_jtag_enable <= avs_writedata[`DCWD_JTAG_BIT];
  end

  // ****************************************************************
  // Avalon-MM slave: waitrequest alternates while a request is held, answer after a high cycle
  // ****************************************************************
  reg [31:0] rd_d;

  always @*
  begin
    rd_d = 32'h00000000;
    case (avs_address)
      `DCWD_ADDR_CFG0: rd_d = w0_q;
      `DCWD_ADDR_CFG2: rd_d = w2_q;
      `DCWD_ADDR_STAT: rd_d = {22'h0, flash_write_protect_count};
      `DCWD_ADDR_RTCFG: rd_d = {29'h0, runtime_jtag_enable, 2'h0};
      `DCWD_ADDR_WPLIM: rd_d = {11'h0, flash_protect_limit};
      default: rd_d = 32'h00000000;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end
    else
    begin
      // Low for one cycle after each high cycle with a request pending; with no request it stays high
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
        avs_readdata <= rd_d;
    end
  end

endmodule // dcwd_decode

// [tb/dcwd_decode_sva.sv]
`timescale 1ns/1ps
module dcwd_decode_sva (
  input wire clk,
  input wire rst,
  input wire avs_read,
  input wire avs_waitrequest,
  input wire [9:0] flash_write_protect_count,
  input wire flash_protect_active,
  input wire [20:0] flash_protect_limit,
  input wire [1:0] debug_channel_select,
  input wire debug_pair_one,
  input wire debug_pair_two,
  input wire debug_pair_three,
  input wire boundary_scan_port_enable,
  input wire runtime_jtag_enable,
  input wire [2:0] pll_input_divide_select,
  input wire [3:0] pll_input_divide_ratio
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_limit_value: assert property (flash_protect_active && flash_write_protect_count != 10'h000
    |-> flash_protect_limit == {1'b0, ~flash_write_protect_count, 10'h000}) else $error("limit bad");
  a_protect_all: assert property (flash_protect_active && flash_write_protect_count == 10'h000
    |-> flash_protect_limit == 21'h1fffff) else $error("full limit bad");
  a_limit_off: assert property (!flash_protect_active |-> flash_protect_limit == 21'h000000)
    else $error("inactive limit bad");
  a_pair_one: assert property (debug_pair_one == (debug_channel_select == 2'h3))
    else $error("pair one bad");
  a_pair_two: assert property (debug_pair_two == (debug_channel_select == 2'h2))
    else $error("pair two bad");
  a_pair_three: assert property (debug_pair_three == (debug_channel_select == 2'h1))
    else $error("pair three bad");
  a_pair_single: assert property ($countones({debug_pair_one, debug_pair_two, debug_pair_three}) <= 1)
    else $error("more than one pair");
  a_jtag_init: assert property ($fell(rst) |=> runtime_jtag_enable == boundary_scan_port_enable)
    else $error("runtime jtag not loaded");
  a_pll_ratio: assert property (pll_input_divide_ratio == (pll_input_divide_select == 3'h7 ? 4'hc :
    pll_input_divide_select == 3'h6 ? 4'ha : {1'b0, pll_input_divide_select} + 4'h1)) else $error("ratio bad");
  // First edge after release loads the outputs, so stability is checked from the third on
  a_hold_static: assert property (!$past(rst) && !$past(rst, 2) |-> $stable(flash_write_protect_count)
    && $stable(pll_input_divide_select)) else $error("decoded value moved");
  a_wait_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("wait low too long");
endmodule // dcwd_decode_sva
bind dcwd_decode dcwd_decode_sva u_sva (.clk, .rst, .avs_read, .avs_waitrequest,
  .flash_write_protect_count, .flash_protect_active, .flash_protect_limit, .debug_channel_select,
  .debug_pair_one, .debug_pair_two, .debug_pair_three, .boundary_scan_port_enable, .runtime_jtag_enable,
  .pll_input_divide_select, .pll_input_divide_ratio);

// [tb/tb_device_config_word_decode.sv]
`timescale 1ns/1ps
module tb_device_config_word_decode;
  logic clk = 1'b0, rst = 1'b1, code_protect = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] cfg_word_zero = 32'h0, cfg_word_two = 32'h0, avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf, pll_input_divide_ratio;
  logic [9:0] flash_write_protect_count;
  logic [20:0] flash_protect_limit;
  logic [1:0] debug_channel_select;
  logic [2:0] pll_input_divide_select;
  logic avs_waitrequest, flash_protect_active, debug_pair_one, debug_pair_two, debug_pair_three;
  logic debug_enable, boundary_scan_port_enable, runtime_jtag_enable;
  int n_fail = 0, check_count = 0, cyc = 0;
  dcwd_decode dut (.clk, .rst, .cfg_word_zero, .cfg_word_two, .code_protect, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .flash_write_protect_count, .flash_protect_active, .flash_protect_limit, .debug_channel_select,
    .debug_pair_one, .debug_pair_two, .debug_pair_three, .debug_enable, .boundary_scan_port_enable,
    .runtime_jtag_enable, .pll_input_divide_select, .pll_input_divide_ratio);
  always #20 clk = ~clk;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low; the watchdog ends a hang
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // One idle edge so the next call never re-drives the strobe in this time step
    @(posedge clk);
  endtask
  task dec(input logic [31:0] w0, input logic [2:0] pd, input logic cp, input logic [20:0] lim,
    input logic [2:0] pairs, input logic [3:0] rat);
    rst <= 1'b1;
    cfg_word_zero <= w0;
    cfg_word_two <= {29'h0, pd};
    code_protect <= cp;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("limit", {11'h0, flash_protect_limit}, {11'h0, lim});
    chk("active", {31'h0, flash_protect_active}, {31'h0, lim != 21'h0});
    chk("select", {30'h0, debug_channel_select}, {30'h0, w0[4:3]});
    chk("pairs", {29'h0, debug_pair_one, debug_pair_two, debug_pair_three}, {29'h0, pairs});
    chk("jtag", {30'h0, boundary_scan_port_enable, runtime_jtag_enable}, {30'h0, {2{w0[2]}}});
    chk("debug", {31'h0, debug_enable}, {31'h0, !cp && !w0[1]});
    chk("pll", {25'h0, pll_input_divide_select, pll_input_divide_ratio}, {25'h0, pd, rat});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_decode;
    dec(32'h0007fffc, 3'h0, 1'b0, 21'h080000, 3'h4, 4'h1);
    dec(32'h000bfff2, 3'h6, 1'b0, 21'h040000, 3'h2, 4'ha);
    // Code protect must override a debug field that asks for enable
    dec(32'h000003ed, 3'h7, 1'b1, 21'h1fffff, 3'h1, 4'hc);
    $display("decode test done");
  endtask
  task t_pll;
    for (int i = 1; i < 6; i++)
      dec(32'h0107ffe0, i[2:0], 1'b0, 21'h000000, 3'h0, 4'(i + 1));
    $display("pll test done");
  endtask
  task t_bus;
    bus(1'b0, 4'h0, 32'h0);
    chk("word zero", q, 32'h0107ffe0);
    bus(1'b1, 4'h0, 32'hffffffff);
    bus(1'b0, 4'h0, 32'h0);
    chk("word zero ro", q, 32'h0107ffe0);
    bus(1'b0, 4'h1, 32'h0);
    chk("word two", q, 32'h00000005);
    bus(1'b0, 4'h2, 32'h0);
    chk("count", q, 32'h000001ff);
    bus(1'b0, 4'h4, 32'h0);
    chk("limit reg", q, 32'h0);
    bus(1'b0, 4'h5, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, 4'h3, 32'h00000004);
    bus(1'b0, 4'h3, 32'h0);
    chk("runtime cfg", q, 32'h00000004);
    chk("scan port", {31'h0, boundary_scan_port_enable}, 32'h0);
    cfg_word_zero <= 32'h0;
    repeat (4) @(posedge clk);
    chk("count held", {22'h0, flash_write_protect_count}, 32'h000001ff);
    $display("bus test done");
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      n_fail++;
      complete_run;
    end
  end
  initial
  begin
    t_decode;
    t_pll;
    t_bus;
    complete_run;
  end
endmodule // tb_device_config_word_decode
